// file: design/spfs_defines.svh
// Timing counts, vectors and reset values of the stop-mode power-fail sequencer.
// Assumes a 10 MHz system clock; all counts derive from it.
`ifndef SPFS_DEFINES_SVH
`define SPFS_DEFINES_SVH

// System clock period
`define SPFS_CLK_PERIOD_NS 100
// Nanopower ring oscillator period (8 kHz), one wake-up timer step of 125 us
`define SPFS_RING_PERIOD_NS 125000
`define SPFS_RING_DIV_CYC ((`SPFS_RING_PERIOD_NS) / (`SPFS_CLK_PERIOD_NS))
// Least time a warning-level supply must persist before it is flagged
`define SPFS_PFW_HOLD_NS 10000
`define SPFS_PFW_HOLD_CYC (((`SPFS_PFW_HOLD_NS) + (`SPFS_CLK_PERIOD_NS) - 1) / (`SPFS_CLK_PERIOD_NS))
// Crystal warmup time
`define SPFS_XTAL_WARMUP_NS 1000000
`define SPFS_XTAL_WARMUP_CYC (((`SPFS_XTAL_WARMUP_NS) + (`SPFS_CLK_PERIOD_NS) - 1) / (`SPFS_CLK_PERIOD_NS))
// Longest CPU release after a pin or watchdog reset goes away
`define SPFS_EXT_REL_MAX_CYC 20
// Restart vectors
`define SPFS_ROM_VEC 16'h8000
`define SPFS_APP_VEC 16'h0000
// Reset value of the stop-monitor disable bit
`define SPFS_MON_DIS_RST 1'h1
// Periodic monitor interval is 2^(base + select) ring clocks
`define SPFS_MON_EXP_BASE 4'ha
`define SPFS_MON_CONT 2'h0
// Wake-up timer interval width
`define SPFS_WT_W 16

`endif

// file: design/spfs_pkg.sv
// Types shared by the stop-mode power-fail sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package spfs_pkg;

	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_POR = 7'h01,
		ST_WARMUP = 7'h02,
		ST_RUN = 7'h04,
		ST_EXT_RST = 7'h08,
		ST_STOP = 7'h10,
		ST_STOP_WARM = 7'h20,
		ST_PF_RESET = 7'h40
	} spfs_state_t;

	// Wake vector reported on stop exit
	typedef enum logic [1:0] {
		VEC_NONE = 2'h0,
		VEC_IO = 2'h1,
		VEC_PF = 2'h2
	} spfs_wake_vec_t;

endpackage

// file: design/spfs_ring_div.sv
// Divider making the 8 kHz ring oscillator tick as a one-cycle enable.
// Assumes clk_i at 10 MHz and a synchronous active-high reset.
`timescale 1ns/1ps
`include "spfs_defines.svh"
module spfs_ring_div import spfs_pkg::*; #(
	parameter int DIV_CYC = `SPFS_RING_DIV_CYC
) (
	input wire logic clk_i,
	input wire logic reset_i,
	spfs_tick_if.div t
);
	localparam int DW = $clog2(DIV_CYC);

	typedef struct packed {
		logic [DW-1:0] cnt;
		logic tick;
	} spfs_div_t;

	spfs_div_t q;
	spfs_div_t n;

	// Free-running count, pulse at wrap
	always_comb begin
		n = q;
		n.tick = 1'h0;
		if (q.cnt == DW'(DIV_CYC - 1)) begin
			n.cnt = '0;
			n.tick = 1'h1;
		end else begin
			n.cnt = q.cnt + DW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign t.tick = q.tick;
endmodule

// file: design/spfs_sequencer.sv
// Stop-mode and power-fail sequencer: top of the block.
// Assumes 10 MHz clk_i, comparator and pin inputs asynchronous,
// watchdog and software strobes synchronous to clk_i.
//
// Functional notes
// - Stop holds the CPU with state kept; I/O, warning, timer, power-fail end it.
// - Wake-up timer steps 125 us on the 8 kHz ring, expiry ends stop.
// - Software stop request enters stop mode.
// - Supply monitor on outside stop and periodic power-fail reset, whatever the disable bit.
// - Stop-monitor disable bit resets to one.
// - Disabled monitor in stop flags nothing and causes no reset.
// - After power-fail reset, sampling is continuous or every 2^11/12/13 ring clocks.
// - Periodic window three ring cycles, third above-threshold period releases reset.
// - Power-fail release waits crystal warmup, restarts at 8000h.
// - Pin or watchdog reset keeps monitor, regulator and crystal on.
// - CPU leaves pin or watchdog reset within fewer than 20 clocks.
// - Warning held for the hold time sets the flag; interrupt only if enabled.
// - A dip shorter than the hold time gives no indication.
// - Below reset threshold: CPU reset, regulator and crystal off, monitor continuous or periodic.
// - Below power-on threshold the device is held in reset.
// - Power-up above power-on threshold warms the crystal with CPU in reset.
// - Warning in stop with monitor enabled warms crystal then exits stop.
// - Warning in stop with monitor disabled leaves the device stopped.
// - Other wake with monitor disabled turns monitor on; warning sets flag.
// - Stop exit with both pending vectors to the higher priority.
`timescale 1ns/1ps
`include "spfs_defines.svh"
module spfs_sequencer import spfs_pkg::*; #(
	parameter int XTAL_WARMUP_CYCLES = `SPFS_XTAL_WARMUP_CYC,
	parameter int PFW_HOLD_CYCLES = `SPFS_PFW_HOLD_CYC,
	parameter bit PF_PRIORITY_HIGH = 1'h1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic vdd_above_por_i,
	input wire logic vdd_above_rst_i,
	input wire logic vdd_above_pfw_i,
	input wire logic io_irq_i,
	input wire logic reset_pin_n_i,
	input wire logic watchdog_rst_i,
	input wire logic stop_req_i,
	input wire logic stop_monitor_disable_we_i,
	input wire logic stop_monitor_disable_i,
	input wire logic [1:0] mon_interval_i,
	input wire logic pf_irq_en_i,
	input wire logic power_fail_flag_clr_i,
	input wire logic wake_en_i,
	input wire logic [`SPFS_WT_W-1:0] wake_interval_i,
	output logic cpu_reset_o,
	output logic cpu_stop_o,
	output logic regulator_en_o,
	output logic crystal_en_o,
	output logic monitor_on_o,
	output logic stop_monitor_disable_o,
	output logic power_fail_flag_o,
	output logic power_fail_irq_o,
	output logic [15:0] restart_vector_o,
	output logic stop_exit_o,
	output logic [1:0] wake_vector_o
);
	// ----------------------------------------
	// Constants and state
	// ----------------------------------------
	localparam int WW = $clog2(XTAL_WARMUP_CYCLES + 1);
	localparam int HW = $clog2(PFW_HOLD_CYCLES + 1);

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		spfs_state_t st;
		logic mon_dis;
		logic [13:0] mon_cnt;
		logic [1:0] win;
		logic per_on;
		logic [HW-1:0] hold_cnt;
		logic [WW-1:0] warm_cnt;
		logic rom_boot;
		logic wake_pf;
		logic wake_io;
		logic flag;
		logic irq;
		logic arm;
		logic stop_exit;
		logic [15:0] vec;
		spfs_wake_vec_t vsel;
		logic cpu_rst;
		logic cpu_stop;
		logic reg_en;
		logic xtal_en;
		logic mon_on;
	} spfs_seq_t;

	spfs_seq_t q;
	spfs_seq_t n;
	spfs_tick_if t();

	logic por_ok;
	logic rst_ok;
	logic pfw_ok;
	logic io_wake;
	logic pin_n;
	logic ext_rst;
	logic filt;
	logic warn;
	logic hit;
	logic [13:0] period;

	// ----------------------------------------
	// Ring divider and wake-up timer
	// ----------------------------------------
	spfs_ring_div u_div (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.t(t.div)
	);

	spfs_wake_timer u_wt (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wake_en_i(wake_en_i),
		.wake_interval_i(wake_interval_i),
		.t(t.timer)
	);

	assign t.arm = q.arm;
	assign t.run = (q.st == ST_STOP);

	// Synchronised comparator and pin levels
	assign por_ok = q.sync2[4];
	assign rst_ok = q.sync2[3];
	assign pfw_ok = q.sync2[2];
	assign io_wake = q.sync2[1];
	assign pin_n = q.sync2[0];
	assign ext_rst = !pin_n || watchdog_rst_i;

	// Warning filter runs only where the monitor is live
	assign filt = (q.st == ST_RUN) || (q.st == ST_STOP_WARM)
		|| ((q.st == ST_STOP) && !q.mon_dis);
	assign warn = filt && rst_ok && !pfw_ok;
	assign hit = warn && (q.hold_cnt == HW'(PFW_HOLD_CYCLES - 1));
	assign period = 14'h1 << (`SPFS_MON_EXP_BASE + {2'h0, mon_interval_i});

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		n = q;
		n.sync1 = {vdd_above_por_i, vdd_above_rst_i, vdd_above_pfw_i, io_irq_i, reset_pin_n_i};
		n.sync2 = q.sync1;
		n.arm = 1'h0;
		n.stop_exit = 1'h0;

		// Software access to the disable bit
		if (stop_monitor_disable_we_i) begin
			n.mon_dis = stop_monitor_disable_i;
		end

		// Warning hold counter, restarts on any break
		if (!warn) begin
			n.hold_cnt = '0;
		end else if (q.hold_cnt != HW'(PFW_HOLD_CYCLES)) begin
			n.hold_cnt = q.hold_cnt + HW'(1);
		end

		// Flag: a new hit beats a clear
		n.flag = (q.flag && !power_fail_flag_clr_i) || hit;

		unique case (q.st)
			ST_POR: begin
				if (por_ok) begin
					n.st = ST_WARMUP;
					n.warm_cnt = '0;
					n.rom_boot = 1'h0;
				end
			end
			ST_WARMUP: begin
				if (!rst_ok) begin
					n.st = ST_PF_RESET;
					n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					n.mon_cnt = '0;
					n.win = '0;
				end else if (q.warm_cnt == WW'(XTAL_WARMUP_CYCLES - 1)) begin
					n.st = ST_RUN;
					n.vec = q.rom_boot ? `SPFS_ROM_VEC : `SPFS_APP_VEC;
				end else begin
					n.warm_cnt = q.warm_cnt + WW'(1);
				end
			end
			ST_RUN: begin
				if (!rst_ok) begin
					n.st = ST_PF_RESET;
					n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					n.mon_cnt = '0;
					n.win = '0;
				end else if (ext_rst) begin
					n.st = ST_EXT_RST;
				end else if (stop_req_i) begin
					n.st = ST_STOP;
					n.arm = 1'h1;
					n.wake_pf = 1'h0;
					n.wake_io = 1'h0;
				end
			end
			ST_EXT_RST: begin
				if (!rst_ok) begin
					n.st = ST_PF_RESET;
					n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					n.mon_cnt = '0;
					n.win = '0;
				end else if (!ext_rst) begin
					n.st = ST_RUN;
					n.vec = `SPFS_APP_VEC;
				end
			end
			ST_STOP: begin
				if (!q.mon_dis && !rst_ok) begin
					n.st = ST_PF_RESET;
					n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					n.mon_cnt = '0;
					n.win = '0;
				end else if (ext_rst) begin
					n.st = ST_EXT_RST;
				end else if (hit || io_wake || t.expire) begin
					n.st = ST_STOP_WARM;
					n.warm_cnt = '0;
					n.wake_pf = hit;
					n.wake_io = io_wake || t.expire;
				end
			end
			ST_STOP_WARM: begin
				if (!rst_ok) begin
					n.st = ST_PF_RESET;
					n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					n.mon_cnt = '0;
					n.win = '0;
				end else if (q.warm_cnt == WW'(XTAL_WARMUP_CYCLES - 1)) begin
					n.st = ST_RUN;
					n.stop_exit = 1'h1;
					// Higher priority source wins the vector
					if ((q.wake_pf || hit) && (PF_PRIORITY_HIGH || !q.wake_io)) begin
						n.vsel = VEC_PF;
					end else begin
						n.vsel = VEC_IO;
					end
				end else begin
					n.warm_cnt = q.warm_cnt + WW'(1);
					n.wake_pf = q.wake_pf || hit;
				end
			end
			ST_PF_RESET: begin
				if (q.per_on) begin
					if (!rst_ok) begin
						// Window failed, restart; periodic mode sleeps until next period
						n.win = '0;
						n.mon_cnt = '0;
						n.per_on = (mon_interval_i == `SPFS_MON_CONT);
					end else if (t.tick) begin
						if (q.win == 2'h2) begin
							n.st = ST_WARMUP;
							n.warm_cnt = '0;
							n.rom_boot = 1'h1;
						end else begin
							n.win = q.win + 2'h1;
						end
					end
				end else if (t.tick) begin
					if (q.mon_cnt == period - 14'h1) begin
						n.per_on = 1'h1;
						n.mon_cnt = '0;
					end else begin
						n.mon_cnt = q.mon_cnt + 14'h1;
					end
				end
			end
		endcase

		// Below power-on threshold overrides everything
		if (!por_ok) begin
			n.st = ST_POR;
			n.per_on = 1'h0;
		end

		// Outputs follow the next state
		n.irq = n.flag && pf_irq_en_i;
		n.cpu_rst = (n.st == ST_POR) || (n.st == ST_WARMUP)
			|| (n.st == ST_EXT_RST) || (n.st == ST_PF_RESET);
		n.cpu_stop = (n.st == ST_STOP) || (n.st == ST_STOP_WARM);
		n.reg_en = (n.st == ST_WARMUP) || (n.st == ST_RUN)
			|| (n.st == ST_EXT_RST) || (n.st == ST_STOP_WARM);
		n.xtal_en = n.reg_en;
		n.mon_on = (n.st == ST_STOP) ? !n.mon_dis
			: (n.st == ST_PF_RESET) ? n.per_on : 1'h1;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.st <= ST_POR;
			q.mon_dis <= `SPFS_MON_DIS_RST;
			q.cpu_rst <= 1'h1;
			q.mon_on <= 1'h1;
			q.vec <= `SPFS_APP_VEC;
			q.vsel <= VEC_NONE;
		end else begin
			q <= n;
		end
	end

	assign cpu_reset_o = q.cpu_rst;
	assign cpu_stop_o = q.cpu_stop;
	assign regulator_en_o = q.reg_en;
	assign crystal_en_o = q.xtal_en;
	assign monitor_on_o = q.mon_on;
	assign stop_monitor_disable_o = q.mon_dis;
	assign power_fail_flag_o = q.flag;
	assign power_fail_irq_o = q.irq;
	assign restart_vector_o = q.vec;
	assign stop_exit_o = q.stop_exit;
	assign wake_vector_o = q.vsel;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_run_ok;
		q.st == ST_RUN && rst_ok && por_ok && !ext_rst;
	endsequence

	sequence s_pf_release;
		q.st == ST_PF_RESET ##1 q.st == ST_WARMUP;
	endsequence

	property p_stop_entry;
		s_run_ok and stop_req_i |=> q.st == ST_STOP && q.cpu_stop && !q.reg_en;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop request not honoured");

	property p_mon_dis_reset;
		$fell(reset_i) |-> q.mon_dis;
	endproperty
	a_mon_dis_reset: assert property (p_mon_dis_reset) else $error("disable bit not one after reset");

	property p_disabled_quiet;
		q.st == ST_STOP && q.mon_dis && por_ok |=> q.st != ST_PF_RESET && !$rose(q.flag);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled monitor acted in stop");

	property p_three_periods;
		s_pf_release |-> $past(q.win, 1) == 2'h2 && q.rom_boot;
	endproperty
	a_three_periods: assert property (p_three_periods) else $error("reset released early");

	property p_rom_vector;
		$rose(q.st == ST_RUN) && $past(q.st == ST_WARMUP) && q.rom_boot |-> q.vec == `SPFS_ROM_VEC;
	endproperty
	a_rom_vector: assert property (p_rom_vector) else $error("power-fail restart vector wrong");

	property p_ext_rails;
		q.st == ST_EXT_RST |-> q.reg_en && q.xtal_en && q.mon_on && q.cpu_rst;
	endproperty
	a_ext_rails: assert property (p_ext_rails) else $error("rails dropped in pin reset");

	property p_ext_release;
		q.st == ST_EXT_RST && !ext_rst && rst_ok && por_ok |-> ##[1:19] !q.cpu_rst;
	endproperty
	a_ext_release: assert property (p_ext_release) else $error("pin reset release too slow");

	property p_irq_gate;
		q.irq |-> q.flag && $past(pf_irq_en_i);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while disabled");

	property p_below_rst;
		q.st == ST_RUN && !rst_ok && por_ok |=> q.st == ST_PF_RESET && q.cpu_rst && !q.reg_en && !q.xtal_en;
	endproperty
	a_below_rst: assert property (p_below_rst) else $error("reset-level supply not handled");

	property p_below_por;
		!por_ok |=> q.st == ST_POR && q.cpu_rst && !q.reg_en;
	endproperty
	a_below_por: assert property (p_below_por) else $error("not held in reset below power-on");

	property p_stop_warn;
		q.st == ST_STOP && hit && rst_ok && por_ok && !ext_rst |=> q.st == ST_STOP_WARM && q.reg_en && q.wake_pf;
	endproperty
	a_stop_warn: assert property (p_stop_warn) else $error("warning did not wake stop");

	property p_vector_pick;
		q.stop_exit && $past(q.wake_pf) && $past(q.wake_io) |-> q.vsel == (PF_PRIORITY_HIGH ? VEC_PF : VEC_IO);
	endproperty
	a_vector_pick: assert property (p_vector_pick) else $error("wrong stop-exit vector");
endmodule

// file: design/spfs_tick_if.sv
// Ring tick and wake-up timer handshake between sequencer parts.
// Assumes all users sit on the same system clock.
`timescale 1ns/1ps
interface spfs_tick_if;
	logic tick;
	logic arm;
	logic run;
	logic expire;

	modport div (output tick);
	modport timer (input tick, input arm, input run, output expire);
	modport seq (input tick, input expire, output arm, output run);
endinterface

// file: design/spfs_wake_timer.sv
// Wake-up timer counting ring ticks while the sequencer is stopped.
// Assumes arm pulses on stop entry and run stays high through stop.
`timescale 1ns/1ps
`include "spfs_defines.svh"
module spfs_wake_timer import spfs_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wake_en_i,
	input wire logic [`SPFS_WT_W-1:0] wake_interval_i,
	spfs_tick_if.timer t
);
	typedef struct packed {
		logic [`SPFS_WT_W-1:0] cnt;
		logic expire;
	} spfs_wt_t;

	spfs_wt_t q;
	spfs_wt_t n;

	// Count 125 us steps, zero interval never expires
	always_comb begin
		n = q;
		n.expire = 1'h0;
		if (!t.run || t.arm) begin
			n.cnt = '0;
		end else if (t.tick && wake_en_i && wake_interval_i != '0) begin
			if (q.cnt == wake_interval_i - `SPFS_WT_W'(1)) begin
				n.cnt = '0;
				n.expire = 1'h1;
			end else begin
				n.cnt = q.cnt + `SPFS_WT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign t.expire = q.expire;

	property p_expire_on_step;
		@(posedge clk_i) disable iff (reset_i)
		q.expire |-> $past(t.tick) && $past(t.run) && $past(wake_en_i);
	endproperty
	a_expire_on_step: assert property (p_expire_on_step) else $error("timer expired off a ring step");
endmodule

// file: verif/spfs_sequencer_tb.sv
// Self-checking bench of the stop-mode power-fail sequencer.
// Assumes short warmup and hold counts set at the instance below.
`timescale 1ns/1ps
module spfs_sequencer_tb import spfs_pkg::*;;
	logic clk_i = 1'h0;
	logic reset_i, io_irq_i, reset_pin_n_i, watchdog_rst_i, stop_req_i;
	logic dis_we, dis_d, pf_irq_en_i, flag_clr, wake_en_i;
	logic [1:0] mon_interval_i, level;
	logic [15:0] wake_interval_i;
	logic above_por, above_rst, above_pfw;
	logic cpu_reset_o, cpu_stop_o, regulator_en_o, crystal_en_o, monitor_on_o;
	logic stop_monitor_disable_o, power_fail_flag_o, power_fail_irq_o, stop_exit_o;
	logic [15:0] restart_vector_o;
	logic [1:0] wake_vector_o;
	int fails = 0;
	int samples_checked = 0;
	int n;

	// Clock, 100 ns period
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	spfs_supply_model supply (.clk_i(clk_i), .level_i(level), .above_por_o(above_por),
		.above_rst_o(above_rst), .above_pfw_o(above_pfw));

	spfs_sequencer #(.XTAL_WARMUP_CYCLES(20), .PFW_HOLD_CYCLES(4)) uut (
		.clk_i(clk_i), .reset_i(reset_i), .vdd_above_por_i(above_por), .vdd_above_rst_i(above_rst),
		.vdd_above_pfw_i(above_pfw), .io_irq_i(io_irq_i), .reset_pin_n_i(reset_pin_n_i),
		.watchdog_rst_i(watchdog_rst_i), .stop_req_i(stop_req_i), .stop_monitor_disable_we_i(dis_we),
		.stop_monitor_disable_i(dis_d), .mon_interval_i(mon_interval_i), .pf_irq_en_i(pf_irq_en_i),
		.power_fail_flag_clr_i(flag_clr), .wake_en_i(wake_en_i), .wake_interval_i(wake_interval_i),
		.cpu_reset_o(cpu_reset_o), .cpu_stop_o(cpu_stop_o), .regulator_en_o(regulator_en_o),
		.crystal_en_o(crystal_en_o), .monitor_on_o(monitor_on_o),
		.stop_monitor_disable_o(stop_monitor_disable_o), .power_fail_flag_o(power_fail_flag_o),
		.power_fail_irq_o(power_fail_irq_o), .restart_vector_o(restart_vector_o),
		.stop_exit_o(stop_exit_o), .wake_vector_o(wake_vector_o));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	// Settled outputs as seen at an edge, before that edge's updates land
	function automatic bit cond(input int k);
		case (k)
			0: return cpu_reset_o === 1'h0;
			1: return cpu_reset_o === 1'h1;
			2: return stop_exit_o === 1'h1;
			default: return regulator_en_o === 1'h1;
		endcase
	endfunction

	task automatic wait_for(input int k, input int lim, output int cnt);
		cnt = 0;
		while (!cond(k) && cnt < lim) begin
			@(posedge clk_i);
			cnt++;
		end
		if (!cond(k)) begin
			fails++;
			$display("wrong value at %0t: wait %0d timed out", $time, k);
		end
	endtask

	task automatic stop();
		@(posedge clk_i);
		stop_req_i <= 1'h1;
		@(posedge clk_i);
		stop_req_i <= 1'h0;
		cyc(1);
	endtask

	task automatic set_mon_dis(input logic v);
		@(posedge clk_i);
		dis_we <= 1'h1;
		dis_d <= v;
		@(posedge clk_i);
		dis_we <= 1'h0;
	endtask

	task automatic clear_flag();
		@(posedge clk_i);
		flag_clr <= 1'h1;
		@(posedge clk_i);
		flag_clr <= 1'h0;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		end_of_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		reset_i <= 1'h1;
		level <= 2'h3;
		reset_pin_n_i <= 1'h1;
		{io_irq_i, watchdog_rst_i, stop_req_i, dis_we, dis_d, pf_irq_en_i, flag_clr, wake_en_i} <= 8'h00;
		mon_interval_i <= 2'h0;
		wake_interval_i <= 16'h0000;
		cyc(20);
		chk(16'(stop_monitor_disable_o), 16'h1, "disable bit reset");
		chk(16'(cpu_reset_o), 16'h1, "reset hold");
		reset_i <= 1'h0;
		wait_for(3, 10, n);
		chk(16'(cpu_reset_o), 16'h1, "cpu held in warmup");
		wait_for(0, 40, n);
		chk(16'(n >= 18), 16'h1, "power-up warmup");
		chk(16'(monitor_on_o), 16'h1, "monitor on in run");
		// Short dip, then a held warning
		level <= 2'h2;
		cyc(2);
		level <= 2'h3;
		cyc(10);
		chk(16'(power_fail_flag_o), 16'h0, "short dip flagged");
		level <= 2'h2;
		cyc(15);
		chk(16'(power_fail_flag_o), 16'h1, "warning flag");
		chk(16'(power_fail_irq_o), 16'h0, "irq while disabled");
		chk(16'(cpu_reset_o), 16'h0, "cpu keeps running");
		pf_irq_en_i <= 1'h1;
		cyc(3);
		chk(16'(power_fail_irq_o), 16'h1, "irq enabled");
		level <= 2'h3;
		cyc(5);
		clear_flag();
		cyc(2);
		chk(16'(power_fail_flag_o), 16'h0, "flag clear");
		// Stop with monitor disabled, wake by I/O with a warning pending
		stop();
		chk(16'(cpu_stop_o), 16'h1, "stop entry");
		chk(16'(regulator_en_o | crystal_en_o | cpu_reset_o), 16'h0, "stop rails");
		chk(16'(monitor_on_o), 16'h0, "monitor off in stop");
		level <= 2'h1;
		cyc(30);
		chk(16'(cpu_reset_o), 16'h0, "reset with monitor off");
		level <= 2'h2;
		cyc(30);
		chk(16'(cpu_stop_o), 16'h1, "warning woke stop");
		chk(16'(power_fail_flag_o), 16'h0, "warning flagged in stop");
		io_irq_i <= 1'h1;
		wait_for(3, 10, n);
		io_irq_i <= 1'h0;
		chk(16'(monitor_on_o), 16'h1, "monitor on at wake");
		wait_for(2, 40, n);
		chk(16'(power_fail_flag_o), 16'h1, "flag at wake");
		chk(16'(wake_vector_o), 16'(VEC_PF), "wake priority");
		cyc(1);
		chk(16'(stop_exit_o | cpu_stop_o), 16'h0, "exit pulse");
		level <= 2'h3;
		cyc(5);
		clear_flag();
		// Stop with monitor enabled, wake by warning
		set_mon_dis(1'h0);
		stop();
		chk(16'(stop_monitor_disable_o), 16'h0, "disable bit write");
		chk(16'(monitor_on_o), 16'h1, "monitor in stop");
		level <= 2'h2;
		wait_for(3, 20, n);
		chk(16'(cpu_stop_o), 16'h1, "stopped in warmup");
		wait_for(2, 40, n);
		chk(16'(n >= 18), 16'h1, "stop warmup");
		chk(16'(wake_vector_o), 16'(VEC_PF), "warning vector");
		level <= 2'h3;
		cyc(5);
		clear_flag();
		// Wake-up timer, two ring steps
		wake_en_i <= 1'h1;
		wake_interval_i <= 16'h0002;
		stop();
		wait_for(2, 4000, n);
		chk(16'(n >= 1250 && n <= 2600), 16'h1, "timer interval");
		chk(16'(wake_vector_o), 16'(VEC_IO), "timer vector");
		wake_en_i <= 1'h0;
		// Pin and watchdog resets
		for (int k = 0; k < 2; k++) begin
			if (k == 0) reset_pin_n_i <= 1'h0;
			else watchdog_rst_i <= 1'h1;
			wait_for(1, 10, n);
			cyc(5);
			chk(16'(regulator_en_o & crystal_en_o & monitor_on_o), 16'h1, "rails in reset");
			if (k == 0) reset_pin_n_i <= 1'h1;
			else watchdog_rst_i <= 1'h0;
			wait_for(0, 30, n);
			chk(16'(n < 20), 16'h1, "release time");
		end
		// Power-fail reset, continuous monitor, then release
		level <= 2'h1;
		wait_for(1, 10, n);
		cyc(2);
		chk(16'(regulator_en_o | crystal_en_o), 16'h0, "rails off");
		chk(16'(monitor_on_o), 16'h1, "continuous monitor");
		level <= 2'h3;
		wait_for(3, 6000, n);
		chk(16'(n >= 2400), 16'h1, "three ring periods");
		wait_for(0, 40, n);
		chk(16'(n >= 18), 16'h1, "pf warmup");
		chk(restart_vector_o, 16'h8000, "restart vector");
		// Periodic monitor, then below power-on
		mon_interval_i <= 2'h1;
		level <= 2'h1;
		wait_for(1, 10, n);
		cyc(3);
		chk(16'(monitor_on_o), 16'h0, "periodic monitor off");
		level <= 2'h0;
		cyc(5);
		chk(16'(cpu_reset_o & ~regulator_en_o), 16'h1, "held below power-on");
		end_of_test();
	end
endmodule

// file: verif/spfs_supply_model.sv
// Supply comparator model standing in front of the sequencer.
// Assumes the bench changes level_i at the rising edge of clk_i.
`timescale 1ns/1ps
module spfs_supply_model (
	input wire logic clk_i,
	input wire logic [1:0] level_i,
	output logic above_por_o = 1'h0,
	output logic above_rst_o = 1'h0,
	output logic above_pfw_o = 1'h0
);
	// Nested thresholds: 0 below power-on, 1 below reset, 2 below warning, 3 good
	always_ff @(posedge clk_i) begin
		above_por_o <= (level_i >= 2'h1);
		above_rst_o <= (level_i >= 2'h2);
		above_pfw_o <= (level_i == 2'h3);
	end
endmodule
